// ==== bench/pin_function_select_portb_low_strobe_tb.sv ====
`timescale 1ns/1ps

module pin_function_select_portb_low_strobe_tb;
	import pin_func_pkg::*;
	logic        mclk, rst, ce, hsel, hwrite, pat_on;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic        hready, hreadyout, hresp;
	logic [15:0] porta_in, porta_out, porta_oe, portb_in, portb_out, portb_oe, ext_b;
	logic [7:0]  portc_in;
	logic [4:0]  timer_out, timer_oe, timer_capture_in, pattern_data, pattern_en;
	logic        chip_select_one_n, chip_select_three_n, upper_column_strobe_n, lower_column_strobe_n;
	logic        upper_strobe_pin_n, lower_strobe_pin_n;
	int          miscompares, compares, cyc;

	assign hready = hreadyout;
	// pin level: our drive wins, otherwise the outside world
	assign portb_in = (portb_oe & portb_out) | (~portb_oe & ext_b);

	pin_function_select_portb_low_strobe u_pin_function_select_portb_low_strobe (.*);
	strobe_timer_model u_strobe_timer_model (.*);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// ************************************
	// checking and bus tasks
	// ************************************
	task close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			miscompares++;
			close_out;
		end
	end

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			miscompares++;
			$display("BAD %s exp %h seen %h", n, e, s);
		end
	endtask

	task bus(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(a, 1'b1, d, q);
	endtask

	function logic sel(input logic [1:0] c, input logic a, input logic b);
		return c == STB_CHIP ? a : c == STB_COLUMN ? b : 1'b1;
	endfunction

	// ************************************
	// scenarios
	// ************************************
	task t_reset;
		logic [31:0] q;
		bus(8'h00, 1'b0, 32'h0, q);
		chk("mode_rst", q, 32'h0);
		bus(8'h04, 1'b0, 32'h0, q);
		chk("strobe_rst", q, 32'h5fff);
		chk("hresp", hresp, 32'h0);
		chk("portb_oe_rst", portb_oe, 32'h0);
		wr(8'h40, 32'hffff_ffff);
		bus(8'h40, 1'b0, 32'h0, q);
		chk("unmapped", q, 32'h0);
		$display("t_reset done");
	endtask

	task t_strobe;
		logic [31:0] q;
		logic [1:0]  c;
		logic        eu, el;
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			wr(8'h04, {16'h0, c, ~c, 12'hfff});
			bus(8'h04, 1'b0, 32'h0, q);
			chk("strobe", q, {16'h0, c, ~c, 12'hfff});
			repeat (3) begin
				@(negedge mclk);
				eu = sel(c, chip_select_one_n, upper_column_strobe_n);
				el = sel(~c, chip_select_three_n, lower_column_strobe_n);
				@(negedge mclk);
				chk("upper_pin", upper_strobe_pin_n, eu);
				chk("lower_pin", lower_strobe_pin_n, el);
			end
			@(posedge mclk);
		end
		$display("t_strobe done");
	endtask

	task t_mode;
		logic [31:0] q;
		logic [1:0]  c;
		logic [4:0]  eo, ed, ec, m;
		wr(8'h14, 32'h1f);
		wr(8'h10, 32'h0a);
		for (int k = 0; k < 4; k++) begin
			c = k[1:0];
			wr(8'h00, {22'h0, {5{c}}});
			bus(8'h00, 1'b0, 32'h0, q);
			chk("mode", q, {22'h0, {5{c}}});
			m = c == PIN_RSVD ? 5'h00 : 5'h1f;
			repeat (3) begin
				@(negedge mclk);
				eo = c == PIN_GPIO ? 5'h1f : c == PIN_TIMER ? timer_oe : c == PIN_PATTERN ? 5'h1f : 5'h00;
				ed = c == PIN_GPIO ? 5'h0a : c == PIN_TIMER ? timer_out : pattern_data;
				ec = c == PIN_TIMER ? portb_in[4:0] : 5'h00;
				@(negedge mclk);
				chk("pin_oe", portb_oe[4:0], eo);
				chk("pin_out", portb_out[4:0] & m, ed & m);
				chk("capture", timer_capture_in, ec);
			end
			@(posedge mclk);
		end
		$display("t_mode done");
	endtask

	task t_gate;
		logic [31:0] q;
		wr(8'h14, 32'hffff);
		wr(8'h10, 32'hffff);
		bus(8'h10, 1'b0, 32'h0, q);
		chk("gated", q, 32'hffea);
		pat_on <= 1'b0;
		@(posedge mclk);
		wr(8'h10, 32'h0015);
		bus(8'h10, 1'b0, 32'h0, q);
		chk("ungated", q, 32'h0015);
		$display("t_gate done");
	endtask

	task t_ports;
		logic [31:0] q;
		wr(8'h0c, 32'hffff);
		wr(8'h08, 32'h1234);
		bus(8'h08, 1'b0, 32'h0, q);
		chk("porta_data", q, 32'h1234);
		chk("porta_out", porta_out, 32'h1234);
		chk("porta_oe", porta_oe, 32'hffff);
		bus(8'h18, 1'b0, 32'h0, q);
		chk("portc", q, 32'ha5);
		$display("t_ports done");
	endtask

	// clock enable low: pins and registers hold, a bus write is lost
	task t_hold;
		logic [31:0] q;
		logic [15:0] o;
		ce <= 1'b0;
		@(posedge mclk);
		o = portb_out;
		wr(8'h0c, 32'h0);
		chk("hold_pins", portb_out, o);
		ce <= 1'b1;
		bus(8'h0c, 1'b0, 32'h0, q);
		chk("hold_bus", q, 32'hffff);
		$display("t_hold done");
	endtask

	initial begin
		rst = 1'b1;
		ce = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h0;
		hsize = 3'h2;
		pat_on = 1'b1;
		porta_in = 16'hc3c3;
		portc_in = 8'ha5;
		ext_b = 16'h5a3c;
		miscompares = 0;
		compares = 0;
		cyc = 0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset;
		t_strobe;
		t_mode;
		t_gate;
		t_ports;
		t_hold;
		close_out;
	end
endmodule

bind pin_function_select_portb_low_strobe pin_select_properties #(.PORT_WIDTH(PORT_WIDTH),
	.PORTB_LOW_PINS(PORTB_LOW_PINS)) u_pin_select_properties (.*);

// ==== bench/pin_select_properties.sv ====
`timescale 1ns/1ps

module pin_select_properties #(
	parameter int PORT_WIDTH     = 16,
	parameter int PORTB_LOW_PINS = 5
) (
	input wire logic                      mclk,
	input wire logic                      rst,
	input wire logic                      ce,
	input wire logic                      hsel,
	input wire logic [31:0]               haddr,
	input wire logic [1:0]                htrans,
	input wire logic                      hwrite,
	input wire logic [31:0]               hwdata,
	input wire logic                      hready,
	input wire logic                      hreadyout,
	input wire logic [31:0]               hrdata,
	input wire logic [PORT_WIDTH-1:0]     portb_in,
	input wire logic [PORT_WIDTH-1:0]     portb_out,
	input wire logic [PORT_WIDTH-1:0]     portb_oe,
	input wire logic [PORTB_LOW_PINS-1:0] timer_out,
	input wire logic [PORTB_LOW_PINS-1:0] timer_oe,
	input wire logic [PORTB_LOW_PINS-1:0] timer_capture_in,
	input wire logic [PORTB_LOW_PINS-1:0] pattern_data,
	input wire logic [PORTB_LOW_PINS-1:0] pattern_en,
	input wire logic                      chip_select_one_n,
	input wire logic                      chip_select_three_n,
	input wire logic                      upper_column_strobe_n,
	input wire logic                      lower_column_strobe_n,
	input wire logic                      upper_strobe_pin_n,
	input wire logic                      lower_strobe_pin_n
);
	// ************************************
	// shadow of the bus-visible mode and strobe registers
	// ************************************
	logic                        ok_r;
	logic                        dp_r;
	logic                        rd_r;
	logic                        w_r;
	logic [7:0]                  a_r;
	logic [2*PORTB_LOW_PINS-1:0] mode_r;
	logic [3:0]                  stb_r;
	logic                        take;
	logic                        up_exp;
	logic                        lo_exp;

	assign take = hsel & htrans[1] & hready & ce & hreadyout;
	assign up_exp = stb_r[3:2] == 2'b01 ? chip_select_one_n : stb_r[3:2] == 2'b10 ? upper_column_strobe_n : 1'b1;
	assign lo_exp = stb_r[1:0] == 2'b01 ? chip_select_three_n : stb_r[1:0] == 2'b10 ? lower_column_strobe_n : 1'b1;

	// ok_r masks the first edge after reset and any edge after a frozen one
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			ok_r <= 1'b0;
			dp_r <= 1'b0;
			rd_r <= 1'b0;
		end else begin
			ok_r <= ce;
			dp_r <= take;
			rd_r <= dp_r & ~w_r;
		end
	end
	always_ff @(posedge mclk) begin
		if (take) begin
			a_r <= haddr[7:0];
			w_r <= hwrite;
		end
	end
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			mode_r <= '0;
			stb_r  <= 4'h5;
		end else if (dp_r && w_r && a_r == 8'h00) begin
			mode_r <= hwdata[2*PORTB_LOW_PINS-1:0];
		end else if (dp_r && w_r && a_r == 8'h04) begin
			stb_r <= hwdata[15:12];
		end
	end

	default clocking dc @(posedge mclk); endclocking
	default disable iff (rst);

	AST_BUS_ONE_WAIT: assert property (take |=> !hreadyout ##1 hreadyout)
		else $error("bus wait state not exactly one cycle");
	AST_MODE_READ: assert property (rd_r && a_r == 8'h00 |-> hrdata[9:0] == mode_r)
		else $error("mode register readback wrong");
	AST_STROBE_READ: assert property (rd_r && a_r == 8'h04 |-> hrdata[31:12] == {16'h0, stb_r})
		else $error("strobe register readback wrong");
	AST_RSVD_ONES: assert property (rd_r && a_r == 8'h04 |-> hrdata[11:0] == 12'hfff)
		else $error("strobe reserved bits not read as one");
	AST_UPPER_PIN: assert property (ok_r |-> upper_strobe_pin_n == $past(up_exp))
		else $error("upper strobe pin wrong source");
	AST_LOWER_PIN: assert property (ok_r |-> lower_strobe_pin_n == $past(lo_exp))
		else $error("lower strobe pin wrong source");
	for (genvar i = 0; i < PORTB_LOW_PINS; i++) begin : g_pin
		AST_PIN_TIMER: assert property (ok_r && $past(mode_r[2*i+:2]) == 2'b10 |->
			portb_oe[i] == $past(timer_oe[i]) && portb_out[i] == $past(timer_out[i]))
			else $error("timer mode pin drive wrong");
		AST_PIN_PATTERN: assert property (ok_r && $past(mode_r[2*i+:2]) == 2'b11 |->
			portb_oe[i] && (!$past(pattern_en[i]) || portb_out[i] == $past(pattern_data[i])))
			else $error("pattern mode pin drive wrong");
		AST_PIN_RSVD: assert property (ok_r && $past(mode_r[2*i+:2]) == 2'b01 |-> !portb_oe[i])
			else $error("reserved mode pin driven");
		AST_CAPTURE: assert property (ok_r |-> timer_capture_in[i] ==
			($past(mode_r[2*i+:2]) == 2'b10 ? $past(portb_in[i]) : 1'b0))
			else $error("capture input wrong");
	end

	cover property (take && hwrite);
	cover property (take && !hwrite);
	cover property (stb_r == 4'h9);
	cover property (mode_r == '1);
endmodule

// ==== bench/strobe_timer_model.sv ====
`timescale 1ns/1ps

module strobe_timer_model (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic       pat_on,
	output logic [4:0]      timer_out,
	output logic [4:0]      timer_oe,
	output logic [4:0]      pattern_data,
	output logic [4:0]      pattern_en,
	output logic            chip_select_one_n,
	output logic            chip_select_three_n,
	output logic            upper_column_strobe_n,
	output logic            lower_column_strobe_n
);
	logic [7:0] cnt_r;

	// every source but pattern_en comes from a counter that steps each cycle, so a stale route cannot pass
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cnt_r <= 8'h00;
		end else begin
			cnt_r <= cnt_r + 8'h01;
		end
	end
	assign timer_out             = cnt_r[4:0];
	assign timer_oe              = cnt_r[7:3];
	assign pattern_data          = ~cnt_r[5:1];
	assign pattern_en            = {5{pat_on}};
	assign chip_select_one_n     = cnt_r[1];
	assign chip_select_three_n   = ~cnt_r[2];
	assign upper_column_strobe_n = cnt_r[0] | cnt_r[3];
	assign lower_column_strobe_n = ~(cnt_r[0] & cnt_r[1]);
endmodule

// ==== hw/pin_func_defines.svh ====
`ifndef PIN_FUNC_DEFINES_SVH
`define PIN_FUNC_DEFINES_SVH

// ************************************
// register byte offsets (low address byte)
// ************************************
`define OFS_PORTB_MODE    8'h00
`define OFS_STROBE_CTRL   8'h04
`define OFS_PORTA_DATA    8'h08
`define OFS_PORTA_DIR     8'h0c
`define OFS_PORTB_DATA    8'h10
`define OFS_PORTB_DIR     8'h14
`define OFS_PORTC_DATA    8'h18

// ************************************
// field positions and reset values
// ************************************
`define STROBE_UPPER_LSB  14
`define STROBE_LOWER_LSB  12
`define STROBE_RESET      16'h5fff
`define STROBE_RSVD_READ  12'hfff
`define PORTB_MODE_RESET  10'h000
`define PORT_DATA_RESET   16'h0000
`define PORT_DIR_RESET    16'h0000

`endif

// ==== hw/pin_func_pkg.sv ====
package pin_func_pkg;

	typedef enum logic [1:0] {
		PIN_GPIO    = 2'b00,
		PIN_RSVD    = 2'b01,
		PIN_TIMER   = 2'b10,
		PIN_PATTERN = 2'b11
	} pin_mode_e;

	typedef enum logic [1:0] {
		STB_RSVD0  = 2'b00,
		STB_CHIP   = 2'b01,
		STB_COLUMN = 2'b10,
		STB_RSVD3  = 2'b11
	} strobe_mode_e;

	typedef enum logic {
		PH_IDLE = 1'b0,
		PH_DATA = 1'b1
	} bus_phase_e;

endpackage

// ==== hw/pin_function_select_portb_low_strobe.sv ====
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`include "pin_func_defines.svh"

// Summary of operation
// R1 - port b pin 4 mode field: 00 gpio, 01 reserved, 10 timer channel a4, 11 pattern bit 4.
// R2 - port b pin 3 mode field: 00 gpio, 01 reserved, 10 timer channel b3, 11 pattern bit 3.
// R3 - port b pin 2 mode field: 00 gpio, 01 reserved, 10 timer channel a3, 11 pattern bit 2.
// R4 - port b pin 1 mode field: 00 gpio, 01 reserved, 10 timer channel b2, 11 pattern bit 1.
// R5 - port b pin 0 mode field: 00 gpio, 01 reserved, 10 timer channel a2, 11 pattern bit 0.
// R6 - the strobe select register is 16 bits, read/write, and loads 5fff at power-on reset.
// R7 - the strobe select register keeps its value through manual reset, standby and sleep.
// R8 - bits 15:14 give chip select one on 01 and upper column strobe on 10; 00 and 11 are reserved.
// R9 - bits 13:12 give chip select three on 01 and lower column strobe on 10; 00 and 11 are reserved.
// R10 - bits 11 to 0 of the strobe select register always read as one.
// R11 - software writes ones into bits 11 to 0 of the strobe select register.
// R12 - there are two 16-bit bidirectional ports a and b and one 8-bit input port c.
// R13 - every port pin is shared between general use and alternate functions; only port b pins 4 to 0 have a function select here.
// R14 - each port has exactly one data register.
// R15 - a port b data bit set to pattern output with pattern enabled ignores software writes.
// R16 - a new pin function takes effect the cycle after the write, glitch free.

module pin_function_select_portb_low_strobe #(
	parameter int PORT_WIDTH      = 16,
	parameter int PORTC_WIDTH     = 8,
	parameter int PORTB_LOW_PINS  = 5
) (
	input  wire logic                       mclk,
	input  wire logic                       rst,
	input  wire logic                       ce,
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic                            hresp,
	output logic [31:0]                     hrdata,
	input  wire logic [PORT_WIDTH-1:0]      porta_in,
	output logic [PORT_WIDTH-1:0]           porta_out,
	output logic [PORT_WIDTH-1:0]           porta_oe,
	input  wire logic [PORT_WIDTH-1:0]      portb_in,
	output logic [PORT_WIDTH-1:0]           portb_out,
	output logic [PORT_WIDTH-1:0]           portb_oe,
	input  wire logic [PORTC_WIDTH-1:0]     portc_in,
	input  wire logic [PORTB_LOW_PINS-1:0]  timer_out,
	input  wire logic [PORTB_LOW_PINS-1:0]  timer_oe,
	output logic [PORTB_LOW_PINS-1:0]       timer_capture_in,
	input  wire logic [PORTB_LOW_PINS-1:0]  pattern_data,
	input  wire logic [PORTB_LOW_PINS-1:0]  pattern_en,
	input  wire logic                       chip_select_one_n,
	input  wire logic                       chip_select_three_n,
	input  wire logic                       upper_column_strobe_n,
	input  wire logic                       lower_column_strobe_n,
	output logic                            upper_strobe_pin_n,
	output logic                            lower_strobe_pin_n
);
	import pin_func_pkg::*;

	localparam int MODE_W = 2 * PORTB_LOW_PINS;
	localparam int HIGH_W = PORT_WIDTH - PORTB_LOW_PINS;

	// ************************************
	// bus slave state
	// ************************************
	bus_phase_e                 phase_r;
	logic [7:0]                 addr_r;
	logic                       write_r;
	logic                       hreadyout_r;
	logic                       hresp_r;
	logic [31:0]                hrdata_r;
	logic [31:0]                rdata_nxt;
	logic                       accept;
	logic                       wr_now;
	logic                       rd_now;

	// ************************************
	// software visible registers
	// ************************************
	logic [MODE_W-1:0]          pb_mode_r;
	logic [3:0]                 strobe_mode_r;
	logic [PORT_WIDTH-1:0]      pa_data_r;
	logic [PORT_WIDTH-1:0]      pa_dir_r;
	logic [PORT_WIDTH-1:0]      pb_data_r;
	logic [PORT_WIDTH-1:0]      pb_dir_r;
	logic [PORT_WIDTH-1:0]      pb_block;
	logic [PORT_WIDTH-1:0]      pb_data_nxt;
	logic [PORT_WIDTH-1:0]      pa_read;
	logic [PORT_WIDTH-1:0]      pb_read;

	// ************************************
	// pin side flops
	// ************************************
	logic [PORT_WIDTH-1:0]      pa_out_r;
	logic [PORT_WIDTH-1:0]      pa_oe_r;
	logic [PORT_WIDTH-1:0]      pb_out_r;
	logic [PORT_WIDTH-1:0]      pb_oe_r;
	logic [PORTB_LOW_PINS-1:0]  capture_r;
	logic                       upper_pin_r;
	logic                       lower_pin_r;
	strobe_mode_e               upper_mode;
	strobe_mode_e               lower_mode;

	pin_route_if #(.N(PORTB_LOW_PINS)) route ();

	// ************************************
	// port b low pin routing
	// ************************************
	assign route.mode         = pb_mode_r; // R1 R2 R3 R4 R5
	assign route.gpio_data    = pb_data_r[PORTB_LOW_PINS-1:0];
	assign route.gpio_dir     = pb_dir_r[PORTB_LOW_PINS-1:0];
	assign route.timer_out    = timer_out;
	assign route.timer_oe     = timer_oe;
	assign route.pattern_data = pattern_data;
	assign route.pattern_en   = pattern_en;
	assign route.pin_in       = portb_in[PORTB_LOW_PINS-1:0];

	portb_low_pin_mux #(
		.N (PORTB_LOW_PINS)
	) u_mux (
		.route (route.mux)
	);

	// ************************************
	// ahb-lite slave
	// ************************************
	// one wait state on every transfer: read data is taken from
	// settled state, so a read straight after a write never sees stale data
	assign accept = hsel & htrans[1] & hready & ce;
	assign wr_now = (phase_r == PH_DATA) & write_r & ce;
	assign rd_now = (phase_r == PH_DATA) & ~write_r & ce;

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			phase_r     <= PH_IDLE;
			addr_r      <= 8'h00;
			write_r     <= 1'b0;
			hreadyout_r <= 1'b1;
		end else if (ce) begin
			if (phase_r == PH_DATA) begin
				phase_r     <= PH_IDLE;
				hreadyout_r <= 1'b1;
			end else if (accept) begin
				phase_r     <= PH_DATA;
				addr_r      <= haddr[7:0];
				write_r     <= hwrite;
				hreadyout_r <= 1'b0;
			end
		end
	end

	// response is always okay, even for unmapped addresses
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hresp_r <= 1'b0;
		end else if (ce) begin
			hresp_r <= 1'b0;
		end
	end

	// ************************************
	// read path
	// ************************************
	// gpio reads follow the direction bit: output returns the register,
	// input returns the pin, whatever function the pin carries
	assign pa_read = (pa_dir_r & pa_data_r) | (~pa_dir_r & porta_in);
	assign pb_read = (pb_dir_r & pb_data_r) | (~pb_dir_r & portb_in);

	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (addr_r)
			`OFS_PORTB_MODE: begin
				rdata_nxt[MODE_W-1:0] = pb_mode_r;
			end
			`OFS_STROBE_CTRL: begin
				rdata_nxt[15:12] = strobe_mode_r;
				rdata_nxt[11:0]  = `STROBE_RSVD_READ; // R10
			end
			`OFS_PORTA_DATA: begin
				rdata_nxt[PORT_WIDTH-1:0] = pa_read;
			end
			`OFS_PORTA_DIR: begin
				rdata_nxt[PORT_WIDTH-1:0] = pa_dir_r;
			end
			`OFS_PORTB_DATA: begin
				rdata_nxt[PORT_WIDTH-1:0] = pb_read;
			end
			`OFS_PORTB_DIR: begin
				rdata_nxt[PORT_WIDTH-1:0] = pb_dir_r;
			end
			`OFS_PORTC_DATA: begin
				rdata_nxt[PORTC_WIDTH-1:0] = portc_in; // R12 R14
			end
			default: begin
				rdata_nxt = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			hrdata_r <= 32'h0000_0000;
		end else if (rd_now) begin
			hrdata_r <= rdata_nxt;
		end
	end

	// ************************************
	// register writes
	// ************************************
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pb_mode_r <= MODE_W'(`PORTB_MODE_RESET);
		end else if (wr_now && addr_r == `OFS_PORTB_MODE) begin
			pb_mode_r <= hwdata[MODE_W-1:0]; // R1 R2 R3 R4 R5
		end
	end

	// only the power-on reset loads 5fff into this; no other reset source exists
	// in this block, so contents survive manual reset and low power states
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			strobe_mode_r <= 4'(`STROBE_RESET >> `STROBE_LOWER_LSB); // R6 R7
		end else if (wr_now && addr_r == `OFS_STROBE_CTRL) begin
			// low twelve bits are not stored, so a careless write cannot upset them
			strobe_mode_r <= hwdata[15:12]; // R6 R11
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pa_data_r <= `PORT_DATA_RESET;
			pa_dir_r  <= `PORT_DIR_RESET;
		end else if (wr_now) begin
			if (addr_r == `OFS_PORTA_DATA) begin
				pa_data_r <= hwdata[PORT_WIDTH-1:0]; // R14
			end
			if (addr_r == `OFS_PORTA_DIR) begin
				pa_dir_r <= hwdata[PORT_WIDTH-1:0];
			end
		end
	end

	assign pb_block    = {{HIGH_W{1'b0}}, route.write_block};
	assign pb_data_nxt = (pb_data_r & pb_block) | (hwdata[PORT_WIDTH-1:0] & ~pb_block); // R15

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pb_data_r <= `PORT_DATA_RESET;
			pb_dir_r  <= `PORT_DIR_RESET;
		end else if (wr_now) begin
			if (addr_r == `OFS_PORTB_DATA) begin
				pb_data_r <= pb_data_nxt; // R14 R15
			end
			if (addr_r == `OFS_PORTB_DIR) begin
				pb_dir_r <= hwdata[PORT_WIDTH-1:0];
			end
		end
	end

	// ************************************
	// pin drive
	// ************************************
	// everything to the pins passes one flop, so a mode change lands on
	// a clock edge and combinational hazards never reach a pad
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pa_out_r <= `PORT_DATA_RESET;
			pa_oe_r  <= `PORT_DIR_RESET;
		end else if (ce) begin
			pa_out_r <= pa_data_r; // R12 R13
			pa_oe_r  <= pa_dir_r;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			pb_out_r  <= `PORT_DATA_RESET;
			pb_oe_r   <= `PORT_DIR_RESET;
			capture_r <= '0;
		end else if (ce) begin
			pb_out_r  <= {pb_data_r[PORT_WIDTH-1:PORTB_LOW_PINS], route.pin_out}; // R13 R16
			pb_oe_r   <= {pb_dir_r[PORT_WIDTH-1:PORTB_LOW_PINS], route.pin_oe}; // R16
			capture_r <= route.timer_in;
		end
	end

	assign upper_mode = strobe_mode_e'(strobe_mode_r[`STROBE_UPPER_LSB-12 +: 2]);
	assign lower_mode = strobe_mode_e'(strobe_mode_r[`STROBE_LOWER_LSB-12 +: 2]);

	// strobes are active low; a reserved code parks the pin inactive high
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			upper_pin_r <= 1'b1;
		end else if (ce) begin
			case (upper_mode)
				STB_CHIP:   upper_pin_r <= chip_select_one_n; // R8
				STB_COLUMN: upper_pin_r <= upper_column_strobe_n; // R8
				default:    upper_pin_r <= 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			lower_pin_r <= 1'b1;
		end else if (ce) begin
			case (lower_mode)
				STB_CHIP:   lower_pin_r <= chip_select_three_n; // R9
				STB_COLUMN: lower_pin_r <= lower_column_strobe_n; // R9
				default:    lower_pin_r <= 1'b1;
			endcase
		end
	end

	// ************************************
	// outputs
	// ************************************
	assign hreadyout          = hreadyout_r;
	assign hresp              = hresp_r;
	assign hrdata             = hrdata_r;
	assign porta_out          = pa_out_r;
	assign porta_oe           = pa_oe_r;
	assign portb_out          = pb_out_r;
	assign portb_oe           = pb_oe_r;
	assign timer_capture_in   = capture_r;
	assign upper_strobe_pin_n = upper_pin_r;
	assign lower_strobe_pin_n = lower_pin_r;

endmodule

// ==== hw/pin_route_if.sv ====
`timescale 1ns/1ps

interface pin_route_if #(parameter int N = 5);
	logic [2*N-1:0] mode;
	logic [N-1:0]   gpio_data;
	logic [N-1:0]   gpio_dir;
	logic [N-1:0]   timer_out;
	logic [N-1:0]   timer_oe;
	logic [N-1:0]   pattern_data;
	logic [N-1:0]   pattern_en;
	logic [N-1:0]   pin_in;
	logic [N-1:0]   pin_out;
	logic [N-1:0]   pin_oe;
	logic [N-1:0]   timer_in;
	logic [N-1:0]   write_block;

	modport ctrl (
		output mode, gpio_data, gpio_dir, timer_out, timer_oe,
		output pattern_data, pattern_en, pin_in,
		input  pin_out, pin_oe, timer_in, write_block
	);
	modport mux (
		input  mode, gpio_data, gpio_dir, timer_out, timer_oe,
		input  pattern_data, pattern_en, pin_in,
		output pin_out, pin_oe, timer_in, write_block
	);
endinterface

// ==== hw/portb_low_pin_mux.sv ====
`timescale 1ns/1ps

module portb_low_pin_mux #(
	parameter int N = 5
) (
	pin_route_if.mux route
);
	import pin_func_pkg::*;

	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pin
			pin_mode_e m;
			assign m = pin_mode_e'(route.mode[2*i +: 2]);

			always_comb begin
				case (m)
					PIN_GPIO: begin
						route.pin_out[i] = route.gpio_data[i];
						route.pin_oe[i]  = route.gpio_dir[i];
					end
					PIN_TIMER: begin
						route.pin_out[i] = route.timer_out[i];
						route.pin_oe[i]  = route.timer_oe[i];
					end
					PIN_PATTERN: begin
						route.pin_out[i] = route.pattern_data[i];
						route.pin_oe[i]  = 1'b1;
					end
					// reserved code: pin left undriven
					default: begin
						route.pin_out[i] = 1'b0;
						route.pin_oe[i]  = 1'b0;
					end
				endcase
			end

			// capture input seen by the timer only while it owns the pin
			assign route.timer_in[i] = (m == PIN_TIMER) & route.pin_in[i];
			assign route.write_block[i] = (m == PIN_PATTERN) & route.pattern_en[i]; // R15
		end
	endgenerate

endmodule
